// file: common/mcfpc_map.vh
`ifndef MCFPC_MAP_VH
`define MCFPC_MAP_VH
// Register indices as printed (not all multiples of four); byte address = index * 4
`define MCFPC_IDX_MCLK 16'h008F
`define MCFPC_IDX_FLASH 16'hFFF2
`define MCFPC_IDX_MISC0 16'hFFF1
`define MCFPC_ADDR_W 18
`define MCFPC_MCLK_RESET 8'h0A
`define MCFPC_FLASH_RESET 8'h10
`define MCFPC_MISC0_RESET 8'h00
`define MCFPC_MCLK_WMASK 8'hE7
`define MCFPC_FLASH_WMASK 8'h30
`define MCFPC_MISC0_WMASK 8'h80
`define MCFPC_BIT_OSC_DIS 7
`define MCFPC_BIT_KEY_DIS 6
`define MCFPC_BIT_CARD_DIS 5
`define MCFPC_BIT_SHORTEN_OFF 5
`define MCFPC_BIT_LONG_SEL 4
`define MCFPC_BIT_GLOBAL_POWER_DOWN 7
`define MCFPC_PD_DELAY 32
`define MCFPC_CLK_PERIOD_NS 100
`define MCFPC_SHORT_NS 40
`define MCFPC_LONG_NS 66
`endif

// file: hdl/mcfpc_top.v
// Overview of operation
// RULE1: Shorten-off bit one passes strobe unchanged
// RULE2: Shorten-off bit zero enables one-shot shortening
// RULE3: Short pulse fixed length, clock independent; here it is counted in pclk cycles, one pclk at the default clock
// RULE4: Long select gives 66 ns, else 40; here both become one pclk cycle at the default 100 ns clock
// RULE5: Software disables shortening above 10 MHz
// RULE6: Oscillator disable stops oscillator and PLL
// RULE7: Power-down gates all, keeps disable bits
// RULE8: Keypad disable gates keypad clock
// RULE9: Card disable gates card logic clock
// RULE10: Card detect stays alive when gated
// RULE11: Multiplier is two times field plus four
// RULE12: Multiplier field resets to two
// RULE13: Software uses power-down, not oscillator disable
// RULE14: Oscillator off 32 cycles after power-down
// RULE15: Reserved bits ignore writes, read reset
`include "mcfpc_map.vh"
module mcfpc_top #(
	parameter CLK_PERIOD_NS = `MCFPC_CLK_PERIOD_NS,
	parameter PD_DELAY = `MCFPC_PD_DELAY
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire flash_read_in,
	output reg flash_read_out,
	output reg osc_pll_enable,
	output reg keypad_clock_enable,
	output reg card_clock_enable,
	output reg card_detect_enable,
	output reg [4:0] mclk_ratio
);
	// Pulse lengths in cycles, rounded down, at least one
	localparam integer SHORT_RAW = `MCFPC_SHORT_NS / CLK_PERIOD_NS;
	localparam integer LONG_RAW = `MCFPC_LONG_NS / CLK_PERIOD_NS;
	localparam integer SHORT_CYC = (SHORT_RAW < 1) ? 1 : SHORT_RAW;
	localparam integer LONG_CYC = (LONG_RAW < 1) ? 1 : LONG_RAW;
	localparam [7:0] SHORT_CNT = SHORT_CYC[7:0];
	localparam [7:0] LONG_CNT = LONG_CYC[7:0];
	localparam [7:0] PD_CNT = PD_DELAY[7:0];
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_HIGH = 3'b010;
	localparam [2:0] ST_WAIT = 3'b100;

	reg [7:0] mclk_ctl;
	reg [7:0] flash_ctl;
	reg [7:0] misc0_ctl;
	reg [2:0] state;
	reg [7:0] pulse_cnt;
	reg [7:0] pd_cnt;
	reg pd_done;
	reg strobe_s1;
	reg strobe_s2;
	reg strobe_s3;
	reg strobe_f;
	reg [7:0] next_reg;
	reg [31:0] next_rdata;
	reg next_err;

	wire access = psel && penable;
	wire word_ok = (paddr[1:0] == 2'b00) && (paddr[31:`MCFPC_ADDR_W] == 0);
	wire [15:0] idx = paddr[`MCFPC_ADDR_W-1:2];
	wire strobe = strobe_f;
	wire strobe_rise = strobe & ~flash_read_out & (state == ST_IDLE);
	wire shorten_off = flash_ctl[`MCFPC_BIT_SHORTEN_OFF];
	wire global_power_down = misc0_ctl[`MCFPC_BIT_GLOBAL_POWER_DOWN];

	// Merge written byte, keeping reserved bits at reset value
	function [7:0] merge;
		input [7:0] wdat;
		input [7:0] rst;
		input [7:0] mask;
		begin
			merge = (wdat & mask) | (rst & ~mask);
		end
	endfunction

	// Register decode, shared by the read mux and the write strobes
	function [2:0] reg_select;
		input [15:0] index;
		begin
			reg_select = 3'b000;
			if (index == `MCFPC_IDX_MCLK) begin
				reg_select = 3'b001;
			end
			if (index == `MCFPC_IDX_FLASH) begin
				reg_select = 3'b010;
			end
			if (index == `MCFPC_IDX_MISC0) begin
				reg_select = 3'b100;
			end
		end
	endfunction

	wire [2:0] sel = reg_select(idx);
	wire wr_en = access && pready && pwrite && word_ok;

	always @* begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		next_reg = 8'h00;
		if (!word_ok) begin
			next_err = 1'b1;
		end else begin
			case (sel)
				3'b001: begin
					next_reg = mclk_ctl;
				end
				3'b010: begin
					next_reg = flash_ctl;
				end
				3'b100: begin
					next_reg = misc0_ctl;
				end
				default: begin
					next_err = 1'b1;
				end
			endcase
			next_rdata = {24'h000000, next_reg};
		end
	end

	// APB slave: one wait state, answer on second access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= access && !pready;
			pslverr <= access && !pready && next_err;
			prdata <= (access && !pready && !pwrite) ? next_rdata : 32'h0000_0000;
		end
	end

	// RULE12: multiplier reset two
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mclk_ctl <= `MCFPC_MCLK_RESET;
		end else if (wr_en && sel[0]) begin
			// RULE15: reserved bits held
			mclk_ctl <= merge(pwdata[7:0], `MCFPC_MCLK_RESET, `MCFPC_MCLK_WMASK);
		end
	end

	// Writes land only on the edge that completes the access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_ctl <= `MCFPC_FLASH_RESET;
		end else if (wr_en && sel[1]) begin
			// RULE15: reserved bits held
			flash_ctl <= merge(pwdata[7:0], `MCFPC_FLASH_RESET, `MCFPC_FLASH_WMASK);
		end
	end

	// Only the power-down bit is kept; the other bits belong elsewhere
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc0_ctl <= `MCFPC_MISC0_RESET;
		end else if (wr_en && sel[2]) begin
			// RULE15: reserved bits held
			misc0_ctl <= merge(pwdata[7:0], `MCFPC_MISC0_RESET, `MCFPC_MISC0_WMASK);
		end
	end

	// RULE14: power-down delay count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_cnt <= 8'h00;
			pd_done <= 1'b0;
		end else if (!global_power_down) begin
			pd_cnt <= 8'h00;
			pd_done <= 1'b0;
		end else if (pd_cnt < PD_CNT - 8'h01) begin
			pd_cnt <= pd_cnt + 8'h01;
		end else begin
			pd_done <= 1'b1;
		end
	end

	// Gating outputs; disable bits themselves never change here
	// RULE6: oscillator disable
	// RULE7: power-down override
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_pll_enable <= 1'b1;
		end else begin
			osc_pll_enable <= !mclk_ctl[`MCFPC_BIT_OSC_DIS] && !pd_done;
		end
	end

	// RULE8: keypad clock gate
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			keypad_clock_enable <= 1'b1;
		end else begin
			keypad_clock_enable <= !mclk_ctl[`MCFPC_BIT_KEY_DIS] && !global_power_down;
		end
	end

	// RULE9: card clock gate
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_clock_enable <= 1'b1;
		end else begin
			card_clock_enable <= !mclk_ctl[`MCFPC_BIT_CARD_DIS] && !global_power_down;
		end
	end

	// RULE10: detect stays alive
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_detect_enable <= 1'b1;
		end else begin
			card_detect_enable <= 1'b1;
		end
	end

	// RULE11: ratio two n plus four
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mclk_ratio <= 5'h08;
		end else begin
			mclk_ratio <= {1'b0, mclk_ctl[2:0], 1'b0} + 5'h04;
		end
	end

	// Strobe arrives from the flash clock domain
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_s1 <= 1'b0;
		end else begin
			strobe_s1 <= flash_read_in;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_s2 <= 1'b0;
		end else begin
			strobe_s2 <= strobe_s1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_s3 <= 1'b0;
		end else begin
			strobe_s3 <= strobe_s2;
		end
	end

	// A level counts only once the last two stages agree, so a one-cycle glitch never starts a pulse
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_f <= 1'b0;
		end else if (strobe_s2 == strobe_s3) begin
			strobe_f <= strobe_s3;
		end
	end

	// One-shot; below one cycle resolution the width is one pclk
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			pulse_cnt <= 8'h00;
			flash_read_out <= 1'b0;
		end else if (shorten_off) begin
			// RULE1: pass strobe through
			state <= ST_IDLE;
			pulse_cnt <= 8'h00;
			flash_read_out <= strobe;
		end else begin
			case (state)
				ST_IDLE: begin
					// RULE2: start one-shot
					if (strobe_rise) begin
						state <= ST_HIGH;
						flash_read_out <= 1'b1;
						// RULE3: fixed width
						// RULE4: long select
						pulse_cnt <= flash_ctl[`MCFPC_BIT_LONG_SEL] ? LONG_CNT - 8'h01 : SHORT_CNT - 8'h01;
					end else begin
						flash_read_out <= 1'b0;
					end
				end
				ST_HIGH: begin
					if (pulse_cnt == 8'h00) begin
						flash_read_out <= 1'b0;
						state <= ST_WAIT;
					end else begin
						pulse_cnt <= pulse_cnt - 8'h01;
					end
				end
				ST_WAIT: begin
					if (!strobe) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
					flash_read_out <= 1'b0;
				end
			endcase
		end
	end
endmodule

// file: testbench/mcfpc_props_properties.sv
module mcfpc_props #(
	parameter PD_DELAY = 32
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire flash_read_in,
	input wire flash_read_out,
	input wire osc_pll_enable,
	input wire keypad_clock_enable,
	input wire card_clock_enable,
	input wire card_detect_enable,
	input wire [4:0] mclk_ratio
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DL = PD_DELAY - 2;
	localparam int DH = PD_DELAY + 4;
	wire wr = psel && penable && pready && pwrite;
	wire wm = wr && paddr == 32'h23C;
	wire wp = wr && paddr == 32'h3FFC4 && pwdata[7];
	reg [2:0] f;
	reg so;
	// Shadow copies, since the stored fields are not visible at the ports
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			f <= 3'h2;
			so <= 1'b0;
		end else begin
			if (wm)
				f <= pwdata[2:0];
			if (wr && paddr == 32'h3FFC8)
				so <= pwdata[5];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ratio; wm |-> ##[1:3] mclk_ratio == {1'b0, f, 1'b0} + 5'h04; endproperty
	a_ratio: assert property (p_ratio) else $error("ratio wrong");
	property p_rst; $rose(presetn) |-> mclk_ratio == 5'h08; endproperty
	a_rst: assert property (p_rst) else $error("ratio reset wrong");
	property p_osc; wm && pwdata[7] |-> ##[1:3] !osc_pll_enable; endproperty
	a_osc: assert property (p_osc) else $error("osc still on");
	property p_key; wm && pwdata[6] |-> ##[1:3] !keypad_clock_enable; endproperty
	a_key: assert property (p_key) else $error("keypad clock on");
	property p_det; !card_clock_enable |-> card_detect_enable; endproperty
	a_det: assert property (p_det) else $error("detect lost");
	property p_pdo; wp |-> ##[DL:DH] !osc_pll_enable; endproperty
	a_pdo: assert property (p_pdo) else $error("osc not off");
	property p_short; !so && $rose(flash_read_out) |=> !flash_read_out; endproperty
	a_short: assert property (p_short) else $error("strobe not short");
	property p_pass; so && $rose(flash_read_out) && flash_read_in |=> flash_read_out; endproperty
	a_pass: assert property (p_pass) else $error("strobe cut");
	c_wm: cover property (wm);
	c_pd: cover property (wp);
	c_sh: cover property (!so && $rose(flash_read_out));
endmodule
bind mcfpc_top mcfpc_props #(.PD_DELAY(PD_DELAY)) u_props (.*);

// file: testbench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam M = 32'h23C, F = 32'h3FFC8, P = 32'h3FFC4;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, flash_read_in = 0, er;
	logic [31:0] paddr = 0, pwdata = 0, r;
	wire [31:0] prdata;
	wire pready, pslverr, flash_read_out, osc_pll_enable, keypad_clock_enable, card_clock_enable, card_detect_enable;
	wire [4:0] mclk_ratio;
	int n_fail = 0, checks = 0, cyc = 0, n;
	always #50 pclk = ~pclk;
	mcfpc_top DUT (.*);
	task chk(string s, logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	task xf(logic w, logic [31:0] a, d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1);
		r = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Strobe held 8 cycles; count cycles the output is high
	task pulse(int e);
		n = 0;
		for (int i = 0; i < 16; i++) begin
			flash_read_in <= i < 8;
			@(posedge pclk);
			n += flash_read_out;
		end
		chk("strobe", n, e);
	endtask
	task results;
		if (n_fail == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc > 1500) begin
			n_fail++;
			results;
		end
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		xf(0, M, 0);
		chk("mclk", r, 8'h0A);
		chk("ratio", mclk_ratio, 5'h08);
		xf(0, F, 0);
		chk("flash", r, 8'h10);
		for (int k = 0; k < 8; k++) begin
			xf(1, M, 8'h18 | k);
			xf(0, M, 0);
			chk("mclk", r, 8'h08 | k);
			chk("ratio", mclk_ratio, 2 * k + 4);
		end
		xf(1, M, 8'hE2);
		repeat (2) @(posedge pclk);
		chk("gates", {osc_pll_enable, keypad_clock_enable, card_clock_enable, card_detect_enable}, 4'h1);
		xf(1, M, 8'h02);
		xf(1, P, 8'h80);
		// Oscillator must outlive the gated clocks so the core can stop cleanly
		repeat (9) @(posedge pclk);
		chk("pd early", {osc_pll_enable, keypad_clock_enable, card_clock_enable}, 3'h4);
		repeat (30) @(posedge pclk);
		chk("pd late", osc_pll_enable, 1'h0);
		xf(0, M, 0);
		chk("mclk kept", r, 8'h0A);
		xf(1, P, 0);
		xf(1, F, 8'hFF);
		xf(0, F, 0);
		chk("flash", r, 8'h30);
		pulse(8);
		xf(1, F, 8'h00);
		pulse(1);
		xf(1, F, 8'h10);
		pulse(1);
		xf(0, 32'h0, 0);
		chk("err", er, 1'h1);
		chk("rdata", r, 32'h0);
		results;
	end
endmodule
